// ---- verilog/bsp_pkg.sv ----
/*
  bsp_pkg: constants, tap states and carriers for the boundary-scan test port.
  Assumes a 10-bit instruction register and 3-bit cell groups per pin.
*/
package bsp_pkg;

  localparam int          IR_LEN        = 10;
  localparam int          ID_LEN        = 32;
  localparam int          NUM_PINS_DEF  = 4;
  localparam int          TLR_ONES      = 5;

  localparam logic [9:0]  IR_EXTEST     = 10'h000;
  localparam logic [9:0]  IR_SAMPLE     = 10'h055;
  localparam logic [9:0]  IR_IDCODE     = 10'h006;
  localparam logic [9:0]  IR_USERCODE   = 10'h007;
  localparam logic [9:0]  IR_BYPASS     = 10'h3FF;
  localparam logic [9:0]  IR_CAPTURE    = 10'h001;
  localparam logic [9:0]  IR_RESET      = IR_IDCODE;

  // arbitrary identity value, not tied to any part
  localparam logic [31:0] ID_CODE_DEF   = 32'h0000_1001;
  localparam logic [31:0] USER_CODE_DEF = 32'h0000_0000;

  localparam logic        BYP_CAPTURE   = 1'b0;

  typedef enum logic [3:0] {
    TLR, RTI,
    SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } bsp_tap_state_t;

  // pin_in is the lsb, so it leaves the chain first
  typedef struct packed {
    logic oe;
    logic out;
    logic pin_in;
  } bsp_cell_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bsp_upin_t;

endpackage

// ---- verilog/bsp_cell_grp.sv ----
/*
  bsp_cell_grp: one 3-bit boundary-scan group (input, output, enable) for a pin.
  Assumes all controls come from the tap on the test clock; trst_n is async.
*/
`timescale 1ns/1ns
module bsp_cell_grp (
  input  wire logic              tck,
  input  wire logic              trst_n,
  input  wire logic              capture_en,
  input  wire logic              shift_en,
  input  wire logic              update_en,
  input  wire bsp_pkg::bsp_cell_t capture,
  input  wire logic              sdi,
  output logic                   sdo,
  output bsp_pkg::bsp_cell_t     upd
);
  import bsp_pkg::*;

  logic [2:0] sh_r;
  bsp_cell_t  upd_r;

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      sh_r <= 3'h0;
    end else if (capture_en) begin
      sh_r <= capture;
    end else if (shift_en) begin
      sh_r <= {sdi, sh_r[2:1]};
    end
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      upd_r <= '0;
    end else if (update_en) begin
      upd_r <= bsp_cell_t'(sh_r);
    end
  end

  assign sdo = sh_r[0];
  assign upd = upd_r;

endmodule // bsp_cell_grp

// ---- verilog/bsp_tap.sv ----
/*
  bsp_tap: boundary-scan test access port with tap state machine, instruction,
  bypass, identification and boundary-scan registers.
  Assumes tck is the controller's clock, unrelated to mclk; core and pads on mclk.
*/
`timescale 1ns/1ns
module bsp_tap #(
  parameter int          NUM_PINS  = bsp_pkg::NUM_PINS_DEF,
  parameter logic [31:0] ID_CODE   = bsp_pkg::ID_CODE_DEF,
  parameter logic [31:0] USER_CODE = bsp_pkg::USER_CODE_DEF
) (
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire logic                  cfg_tap_en,
  input  wire logic                  tck,
  input  wire logic                  trst_n,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  output logic                       tdo_o,
  output logic                       tdo_oe,
  input  wire logic                  usr_tdo_d,
  input  wire logic                  usr_tdo_en,
  output logic                       usr_tdo_o,
  output logic                       usr_tdo_oe,
  output bsp_pkg::bsp_upin_t         usr_pin_in,
  input  wire logic [NUM_PINS-1:0]   core_out,
  input  wire logic [NUM_PINS-1:0]   core_oe,
  output logic [NUM_PINS-1:0]        core_in,
  input  wire logic [NUM_PINS-1:0]   pad_in,
  output logic [NUM_PINS-1:0]        pad_out,
  output logic [NUM_PINS-1:0]        pad_oe
);
  import bsp_pkg::*;
  if (NUM_PINS < 1) begin : g_bad_pins
    $error("bsp_tap: NUM_PINS must be at least 1");
  end

  // tck domain
  logic                       en_s1_r;
  logic                       en_s2_r;
  bsp_tap_state_t             state_r;
  bsp_tap_state_t             state_nxt;
  logic [IR_LEN-1:0]          ir_sh_r;
  logic [IR_LEN-1:0]          ir_r;
  logic                       byp_r;
  logic [ID_LEN-1:0]          id_sh_r;
  logic                       ext_mode_r;
  logic                       upd_tgl_r;
  logic                       tdo_r;
  logic                       tdo_oe_r;
  bsp_cell_t [NUM_PINS-1:0]   cap_s1_r;
  bsp_cell_t [NUM_PINS-1:0]   cap_s2_r;
  bsp_cell_t [NUM_PINS-1:0]   upd_w;
  logic [NUM_PINS:0]          chain;
  logic                       sel_bsr;
  logic                       sel_id;
  logic                       sel_uc;
  logic                       dr_out;

  // mclk domain
  logic                       tap_en_r;
  logic                       ext_s1_r;
  logic                       ext_s2_r;
  logic                       tgl_s1_r;
  logic                       tgl_s2_r;
  logic                       tgl_s3_r;
  bsp_cell_t [NUM_PINS-1:0]   shadow_r;
  logic [NUM_PINS-1:0]        pad_s1_r;
  logic [NUM_PINS-1:0]        pad_s2_r;
  logic [NUM_PINS-1:0]        pad_out_r;
  logic [NUM_PINS-1:0]        pad_oe_r;
  logic [NUM_PINS-1:0]        core_in_r;
  bsp_upin_t                  upin_s1_r;
  bsp_upin_t                  upin_s2_r;
  bsp_upin_t                  upin_r;
  logic                       usr_tdo_r;
  logic                       usr_tdo_oe_r;

  // enable crosses as a level; tap parks in reset while disabled
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
    end else begin
      en_s1_r <= tap_en_r;
      en_s2_r <= en_s1_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TLR:    state_nxt = tms ? TLR    : RTI;
      RTI:    state_nxt = tms ? SEL_DR : RTI;
      SEL_DR: state_nxt = tms ? SEL_IR : CAP_DR;
      CAP_DR: state_nxt = tms ? EX1_DR : SHF_DR;
      SHF_DR: state_nxt = tms ? EX1_DR : SHF_DR;
      EX1_DR: state_nxt = tms ? UPD_DR : PAU_DR;
      PAU_DR: state_nxt = tms ? EX2_DR : PAU_DR;
      EX2_DR: state_nxt = tms ? UPD_DR : SHF_DR;
      UPD_DR: state_nxt = tms ? SEL_DR : RTI;
      SEL_IR: state_nxt = tms ? TLR    : CAP_IR;
      CAP_IR: state_nxt = tms ? EX1_IR : SHF_IR;
      SHF_IR: state_nxt = tms ? EX1_IR : SHF_IR;
      EX1_IR: state_nxt = tms ? UPD_IR : PAU_IR;
      PAU_IR: state_nxt = tms ? EX2_IR : PAU_IR;
      EX2_IR: state_nxt = tms ? UPD_IR : SHF_IR;
      UPD_IR: state_nxt = tms ? SEL_DR : RTI;
    endcase
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      state_r <= TLR;
    end else if (!en_s2_r) begin
      state_r <= TLR;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_sh_r <= IR_CAPTURE;
    end else if (state_r == CAP_IR) begin
      ir_sh_r <= IR_CAPTURE;
    end else if (state_r == SHF_IR) begin
      ir_sh_r <= {tdi, ir_sh_r[IR_LEN-1:1]};
    end
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_r <= IR_RESET;
    end else if (state_r == TLR) begin
      ir_r <= IR_RESET;
    end else if (state_r == UPD_IR) begin
      ir_r <= ir_sh_r;
    end
  end

  // decode; unknown codes fall to bypass
  always_comb begin
    sel_bsr = (ir_r == IR_EXTEST) || (ir_r == IR_SAMPLE);
    sel_id  = (ir_r == IR_IDCODE);
    sel_uc  = (ir_r == IR_USERCODE);
  end

  // shift paths take tdi on rising tck
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      byp_r <= BYP_CAPTURE;
    end else if (state_r == CAP_DR) begin
      byp_r <= BYP_CAPTURE;
    end else if (state_r == SHF_DR) begin
      byp_r <= tdi;
    end
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      id_sh_r <= '0;
    end else if (state_r == CAP_DR && (sel_id || sel_uc)) begin
      id_sh_r <= sel_id ? ID_CODE : USER_CODE;
    end else if (state_r == SHF_DR && (sel_id || sel_uc)) begin
      id_sh_r <= {tdi, id_sh_r[ID_LEN-1:1]};
    end
  end

  // pins and core sampled via two flops, no feedback to them
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      cap_s1_r <= '0;
      cap_s2_r <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        cap_s1_r[i] <= '{oe: core_oe[i], out: core_out[i], pin_in: pad_in[i]};
      end
      cap_s2_r <= cap_s1_r;
    end
  end

  assign chain[NUM_PINS] = tdi;
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_cell
    bsp_cell_grp u_grp (
      .tck        (tck),
      .trst_n     (trst_n),
      .capture_en (state_r == CAP_DR && sel_bsr),
      .shift_en   (state_r == SHF_DR && sel_bsr),
      .update_en  (state_r == UPD_DR && sel_bsr),
      .capture    (cap_s2_r[g]),
      .sdi        (chain[g+1]),
      .sdo        (chain[g]),
      .upd        (upd_w[g])
    );
  end

  // mode level and update event toward mclk
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ext_mode_r <= 1'b0;
      upd_tgl_r  <= 1'b0;
    end else begin
      ext_mode_r <= (ir_r == IR_EXTEST);
      if (state_r == UPD_DR && sel_bsr) begin
        upd_tgl_r <= ~upd_tgl_r;
      end
    end
  end

  always_comb begin
    if (sel_bsr) begin
      dr_out = chain[0];
    end else if (sel_id || sel_uc) begin
      dr_out = id_sh_r[0];
    end else begin
      dr_out = byp_r;
    end
  end

  // falling edge keeps half a period of hold for the tester
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_oe_r <= (state_r == SHF_IR) || (state_r == SHF_DR);
      tdo_r    <= (state_r == SHF_IR) ? ir_sh_r[0] : dr_out;
    end
  end

  assign tdo_o  = tdo_r;
  assign tdo_oe = tdo_oe_r;

  // mclk side: configuration enable
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tap_en_r <= 1'b1;
    end else begin
      tap_en_r <= cfg_tap_en;
    end
  end

  // update data is quiet between events, so a toggle handshake suffices
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
      shadow_r <= '0;
    end else begin
      ext_s1_r <= ext_mode_r;
      ext_s2_r <= ext_s1_r;
      tgl_s1_r <= upd_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
      if (tgl_s2_r ^ tgl_s3_r) begin
        shadow_r <= upd_w;
      end
    end
  end

  // extest forces pins from update stage
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pad_s1_r  <= '0;
      pad_s2_r  <= '0;
      pad_out_r <= '0;
      pad_oe_r  <= '0;
      core_in_r <= '0;
    end else begin
      pad_s1_r <= pad_in;
      pad_s2_r <= pad_s1_r;
      for (int i = 0; i < NUM_PINS; i++) begin
        pad_out_r[i] <= ext_s2_r ? shadow_r[i].out    : core_out[i];
        pad_oe_r[i]  <= ext_s2_r ? shadow_r[i].oe     : core_oe[i];
        core_in_r[i] <= ext_s2_r ? shadow_r[i].pin_in : pad_s2_r[i];
      end
    end
  end

  // disabled port hands pins to user logic
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      upin_s1_r    <= '0;
      upin_s2_r    <= '0;
      upin_r       <= '0;
      usr_tdo_r    <= 1'b0;
      usr_tdo_oe_r <= 1'b0;
    end else begin
      upin_s1_r    <= '{tck: tck, tms: tms, tdi: tdi};
      upin_s2_r    <= upin_s1_r;
      upin_r       <= tap_en_r ? '0 : upin_s2_r;
      usr_tdo_r    <= usr_tdo_d;
      usr_tdo_oe_r <= !tap_en_r && usr_tdo_en;
    end
  end

  assign usr_pin_in = upin_r;
  assign usr_tdo_o  = usr_tdo_r;
  assign usr_tdo_oe = usr_tdo_oe_r;
  assign pad_out    = pad_out_r;
  assign pad_oe     = pad_oe_r;
  assign core_in    = core_in_r;
endmodule // bsp_tap

// ---- verif/bsp_tap_sva.sv ----
/*
  bsp_tap_chk: port-level assertions for the boundary-scan test port.
  Assumes it is bound onto bsp_tap; tck stands low between frames.
*/
`timescale 1ns/1ns
module bsp_tap_chk #(
  parameter int NUM_PINS = 4
) (
  input wire logic                mclk,
  input wire logic                rstn,
  input wire logic                cfg_tap_en,
  input wire logic                tck,
  input wire logic                trst_n,
  input wire logic                tms,
  input wire logic                tdo_o,
  input wire logic                tdo_oe,
  input wire logic                usr_tdo_d,
  input wire logic                usr_tdo_en,
  input wire logic                usr_tdo_o,
  input wire logic                usr_tdo_oe,
  input wire bsp_pkg::bsp_upin_t  usr_pin_in,
  input wire logic [NUM_PINS-1:0] core_out,
  input wire logic [NUM_PINS-1:0] core_in,
  input wire logic [NUM_PINS-1:0] pad_in,
  input wire logic [NUM_PINS-1:0] pad_out
);
  import bsp_pkg::*;
  chk_tdo_reset_off: assert property (@(posedge mclk) disable iff (!rstn) !trst_n |-> !tdo_oe)
    else $error("tdo driven in test reset");
  chk_tdo_fall_only: assert property (@(posedge mclk) disable iff (!trst_n) tck && $past(tck) |-> $stable(tdo_o))
    else $error("tdo moved while tck high");
  chk_shift_entry: assert property (@(negedge tck) disable iff (!trst_n) $rose(tdo_oe) |-> !$past(tms))
    else $error("tdo enabled without shift entry");
  chk_shift_exit: assert property (@(negedge tck) disable iff (!trst_n) $fell(tdo_oe) |-> $past(tms) || !cfg_tap_en)
    else $error("tdo released while still shifting");
  chk_five_ones: assert property (@(negedge tck) disable iff (!trst_n) tms [*5] |-> !tdo_oe)
    else $error("shift survives five ones");
  chk_port_off_quiet: assert property (@(negedge tck) disable iff (!trst_n) (!cfg_tap_en) [*5] |-> !tdo_oe)
    else $error("tdo driven by disabled port");
  chk_user_in_zero: assert property (@(posedge mclk) disable iff (!rstn) cfg_tap_en [*5] |-> usr_pin_in == '0)
    else $error("user pin inputs leak");
  chk_usr_oe_cause: assert property (@(posedge mclk) disable iff (!rstn)
    usr_tdo_oe |-> $past(usr_tdo_en) && !$past(cfg_tap_en, 2) && usr_tdo_o == $past(usr_tdo_d))
    else $error("user tdo driver wrong");
  chk_pad_follow: assert property (@(posedge mclk) disable iff (!rstn) (!trst_n) [*4] |-> pad_out == $past(core_out))
    else $error("pad output not core value");
  chk_core_in_lag: assert property (@(posedge mclk) disable iff (!rstn) (!trst_n) [*6] |-> core_in == $past(pad_in, 3))
    else $error("core input lag wrong");
endmodule // bsp_tap_chk

bind bsp_tap bsp_tap_chk #(.NUM_PINS(NUM_PINS)) u_chk (.mclk(mclk), .rstn(rstn), .cfg_tap_en(cfg_tap_en), .tck(tck),
  .trst_n(trst_n), .tms(tms), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .usr_tdo_d(usr_tdo_d), .usr_tdo_en(usr_tdo_en),
  .usr_tdo_o(usr_tdo_o), .usr_tdo_oe(usr_tdo_oe), .usr_pin_in(usr_pin_in), .core_out(core_out),
  .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out));

// ---- verif/bsp_ctl_model.sv ----
/*
  bsp_ctl_model: behavioural scan controller driving tck, tms, tdi and trst_n.
  Assumes tdo is a pulled-up wire; tck stands low between frames.
*/
`timescale 1ns/1ns
module bsp_ctl_model (
  output logic     tck,
  output logic     tms,
  output logic     tdi,
  output logic     trst_n,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
    // a real falling edge, so the async reset is seen at start
    #1 trst_n = 1'b0;
  end
  // keep tck edges off the even-ns mclk grid
  task automatic align();
    if ($time % 2 == 0) #1;
  endtask
  task automatic bit1(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #6 tck = 1'b1;
    q = tdo;
    #6 tck = 1'b0;
  endtask
  task automatic idle(input int n, input logic m);
    logic q;
    align();
    repeat (n) bit1(m, 1'b0, q);
  endtask
  task automatic rst();
    align();
    trst_n = 1'b0;
    #30 trst_n = 1'b1;
    idle(3, 1'b1);
    idle(1, 1'b0);
  endtask
  task automatic scan(input logic ir, input logic [63:0] din, input int n, output logic [63:0] dout);
    logic q;
    dout = '0;
    align();
    bit1(1'b1, 1'b0, q);
    if (ir) bit1(1'b1, 1'b0, q);
    bit1(1'b0, 1'b0, q);
    bit1(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      bit1(i == n - 1, din[i], q);
      dout[i] = q;
    end
    bit1(1'b1, 1'b0, q);
    bit1(1'b0, 1'b0, q);
  endtask
endmodule // bsp_ctl_model

// ---- verif/bsp_tap_tb_top.sv ----
/*
  bsp_tap_tb_top: self-checking bench for the test port with random pad traffic.
  Assumes bsp_ctl_model plays the controller and the checker is bound.
*/
`timescale 1ns/1ns
module bsp_tap_tb_top;
  import bsp_pkg::*;
  localparam int NP = 4;
  logic            mclk, rstn, cfg_tap_en, usr_tdo_d, usr_tdo_en, usr_tdo_o, usr_tdo_oe;
  logic            tck, tms, tdi, trst_n, tdo_o, tdo_oe;
  bsp_upin_t       usr_pin_in;
  logic [NP-1:0]   core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
  logic [31:0]     rs;
  logic [63:0]     q, p;
  logic [9:0]      codes [4] = '{IR_IDCODE, IR_USERCODE, IR_BYPASS, 10'h2A3};
  int              err_count, checks;
  tri1             tdo_pin;
  assign tdo_pin = tdo_oe ? tdo_o : (usr_tdo_oe ? usr_tdo_o : 1'bz);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  bsp_tap #(.NUM_PINS(NP)) i_dut (.mclk(mclk), .rstn(rstn), .cfg_tap_en(cfg_tap_en), .tck(tck), .trst_n(trst_n),
    .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .usr_tdo_d(usr_tdo_d), .usr_tdo_en(usr_tdo_en),
    .usr_tdo_o(usr_tdo_o), .usr_tdo_oe(usr_tdo_oe), .usr_pin_in(usr_pin_in), .core_out(core_out),
    .core_oe(core_oe), .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
  bsp_ctl_model i_ctl (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo_pin));
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [63:0] cells(input logic [NP-1:0] a, input logic [NP-1:0] b, input logic [NP-1:0] c);
    logic [63:0] e;
    e = '0;
    for (int i = 0; i < NP; i++) e[3*i +: 3] = {c[i], b[i], a[i]};
    return e;
  endfunction
  function automatic logic [NP-1:0] fld(input logic [63:0] v, input int o);
    for (int i = 0; i < NP; i++) fld[i] = v[3*i+o];
  endfunction
  // bypass delays the stream one bit behind its capture zero
  function automatic logic [63:0] exp_dr(input logic [9:0] c, input logic [63:0] d);
    case (c)
      IR_IDCODE:   return 64'(ID_CODE_DEF);
      IR_USERCODE: return 64'(USER_CODE_DEF);
      default:     return {d[62:0], BYP_CAPTURE};
    endcase
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
  initial begin
    rs = 32'h6F79;
    {rstn, usr_tdo_d, usr_tdo_en, core_out, core_oe, pad_in} = '0;
    cfg_tap_en = 1'b1;
    repeat (8) @(posedge mclk);
    @(negedge mclk) rstn = 1'b1;
    // random pad traffic while test reset still holds
    repeat (16) @(negedge mclk) begin
      pad_in = NP'(xs());
      core_out = NP'(xs());
    end
    i_ctl.rst();
    chk(64'(tdo_oe), 64'h0, "tdo idle");
    i_ctl.scan(1'b0, 64'h0, 32, q);
    chk(q & 64'hFFFF_FFFF, 64'(ID_CODE_DEF), "reset instruction");
    foreach (codes[k]) begin
      p = {xs(), xs()};
      i_ctl.scan(1'b1, 64'(codes[k]), IR_LEN, q);
      chk(q & 64'h3FF, 64'(IR_CAPTURE), "ir capture");
      i_ctl.scan(1'b0, p, 32, q);
      chk(q & 64'hFFFF_FFFF, exp_dr(codes[k], p) & 64'hFFFF_FFFF, "dr path");
    end
    @(negedge mclk);
    pad_in = NP'(xs());
    core_out = NP'(xs());
    core_oe = NP'(xs());
    p = 64'(xs());
    i_ctl.scan(1'b1, 64'(IR_SAMPLE), IR_LEN, q);
    i_ctl.scan(1'b0, p, 3 * NP, q);
    chk(q & 64'hFFF, cells(pad_in, core_out, core_oe), "sample capture");
    chk(64'(pad_out), 64'(core_out), "normal drive");
    i_ctl.scan(1'b1, 64'(IR_EXTEST), IR_LEN, q);
    i_ctl.idle(2, 1'b0);
    repeat (8) @(negedge mclk);
    chk(64'(pad_out), 64'(fld(p, 1)), "extest drive");
    chk(64'(pad_oe), 64'(fld(p, 2)), "extest enable");
    chk(64'(core_in), 64'(fld(p, 0)), "extest input");
    i_ctl.idle(TLR_ONES, 1'b1);
    i_ctl.idle(1, 1'b0);
    repeat (8) @(negedge mclk);
    chk(64'(pad_out), 64'(core_out), "release after five ones");
    i_ctl.scan(1'b0, 64'h0, 32, q);
    chk(q & 64'hFFFF_FFFF, 64'(ID_CODE_DEF), "ir back to id");
    @(negedge mclk);
    cfg_tap_en = 1'b0;
    usr_tdo_en = 1'b1;
    usr_tdo_d = 1'(xs());
    i_ctl.idle(3, 1'b1);
    i_ctl.scan(1'b0, 64'h0, 8, q);
    chk(q & 64'hFF, 64'({8{usr_tdo_d}}), "user owns tdo");
    i_ctl.idle(1, 1'b1);
    repeat (6) @(negedge mclk);
    chk(64'(usr_pin_in), 64'h2, "user pin inputs");
    cfg_tap_en = 1'b1;
    usr_tdo_en = 1'b0;
    i_ctl.idle(3, 1'b1);
    i_ctl.idle(1, 1'b0);
    repeat (6) @(negedge mclk);
    chk(64'(usr_pin_in), 64'h0, "port back");
    chk(64'(tdo_pin), 64'h1, "tdo floats high");
    wrap_up();
  end
endmodule // bsp_tap_tb_top
